// ===== nsp_pkg.sv
// Contract
// R1 - status enabled: send status frame when any rotation begins or objective leaves
// R2 - status enabled: send status frame when rotation ends or objective enters
// R3 - shutter mode: send shutter close command at rotation start or objective leaving
// R4 - shutter mode: send further shutter command at rotation end or objective entering
// R5 - forward step command moves nosepiece one position forward
// R6 - guarded reverse step moves back one position, refusing 1 to 5
// R7 - unrestricted reverse step moves back one position, 1 to 5 allowed
// R8 - goto command with one digit moves directly to position 1..5
// R9 - control commands reply o+command+CR, or n+command+error code+CR
// R10 - position query returns digit 1..5, or 0 when position unknown
// R11 - read commands reply a+command+data+CR, failures use the n form
// R12 - revision query returns V, digit, period, two digits
// R13 - name query returns a fixed product name string
// R14 - status setting write takes digit 0..3: off, on, shutter A, shutter B
// R15 - status setting query returns last stored digit 0..3
// R16 - status event frame id s carries 0 at start, position at end
// R17 - host never answers status frames; device never waits for it
// R18 - restore defaults returns settings, status output included, to default then acks
// R19 - frame is id char, three command chars, optional data, CR
// R20 - error codes a, b, d, f, 4, 5 as defined
// R21 - link is 8N1 at 9600 or 19200 bps, outside this block
// R22 - host uses c for actions and settings, r for reads
// R23 - out of range digit gives invalid data error, nothing changes
`default_nettype none
package nsp_pkg;
  localparam int CLK_KHZ = 50000;
  localparam int MOVE_TIMEOUT_MS = 2000;
  localparam int RX_MAX = 8;
  localparam int FRAME_BYTES = 16;
  localparam logic [7:0] CHR_CR = 8'h0D;
  localparam logic [7:0] CHR_NUL = 8'h00;
  localparam logic [7:0] CHR_QMARK = 8'h3F;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_ONE = 8'h31;
  localparam logic [7:0] CHR_THREE = 8'h33;
  localparam logic [7:0] CHR_FIVE = 8'h35;
  localparam logic [7:0] ID_CTL = 8'h63;
  localparam logic [7:0] ID_READ = 8'h72;
  localparam logic [7:0] ID_ACK_CTL = 8'h6F;
  localparam logic [7:0] ID_ACK_RD = 8'h61;
  localparam logic [7:0] ID_NAK = 8'h6E;
  localparam logic [7:0] ID_STATUS = 8'h73;
  localparam logic [7:0] ERR_CMD = 8'h61;
  localparam logic [7:0] ERR_DATA = 8'h62;
  localparam logic [7:0] ERR_TIMEOUT = 8'h64;
  localparam logic [7:0] ERR_FORBID = 8'h66;
  localparam logic [7:0] ERR_OVF = 8'h34;
  localparam logic [7:0] ERR_HW = 8'h35;
  localparam logic [23:0] CMD_FWD = 24'h52_4357;
  localparam logic [23:0] CMD_REV_G = 24'h52_4352;
  localparam logic [23:0] CMD_REV_U = 24'h52_4343;
  localparam logic [23:0] CMD_GOTO = 24'h52_4443;
  localparam logic [23:0] CMD_POS_Q = 24'h52_4152;
  localparam logic [23:0] CMD_REV_Q = 24'h56_4552;
  localparam logic [23:0] CMD_NAME_Q = 24'h50_4E4D;
  localparam logic [23:0] CMD_STAT_W = 24'h53_4153;
  localparam logic [23:0] CMD_STAT_Q = 24'h53_4152;
  localparam logic [23:0] CMD_STAT_EV = 24'h53_4145;
  localparam logic [23:0] CMD_DEFAULTS = 24'h44_4546;
  localparam logic [2:0] POS_NONE = 3'h0;
  localparam logic [2:0] POS_FIRST = 3'h1;
  localparam logic [2:0] POS_LAST = 3'h5;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_STATUS = 2'h1;
  localparam logic [1:0] MODE_SHUT_A = 2'h2;
  localparam logic [1:0] MODE_SHUT_B = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_REPLY = 2'b10
  } nsp_state_t;

  typedef enum logic [1:0] {
    DK_NONE = 2'b00,
    DK_CHAR = 2'b01,
    DK_VER = 2'b10,
    DK_NAME = 2'b11
  } nsp_dkind_t;
endpackage
`default_nettype wire

// ===== nsp_txframe.sv
`timescale 1ns/100ps
`default_nettype none
module nsp_txframe import nsp_pkg::*; #(
  parameter int NBYTES = FRAME_BYTES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic load,
  input wire logic [NBYTES*8-1:0] frame,
  input wire logic [4:0] len,
  output logic busy,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);
  logic [7:0] mem [0:NBYTES-1];
  logic [3:0] idx;
  logic [3:0] last;

  assign busy = tx_valid;

  always_ff @(posedge clk_sys) begin
    if (load) begin
      for (int i = 0; i < NBYTES; i++) begin
        mem[i] <= frame[i*8 +: 8];
      end
    end
  end

  // the next byte is fetched on the handshake so tx_data stays a flop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idx <= 4'h0;
      last <= 4'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (load) begin
      idx <= 4'h0;
      last <= 4'(len - 5'd1);
      tx_valid <= 1'b1;
      tx_data <= frame[7:0];
    end else if (tx_valid && tx_ready) begin
      if (idx == last) begin
        tx_valid <= 1'b0;
      end else begin
        idx <= idx + 4'h1;
        tx_data <= mem[4'(idx + 4'h1)];
      end
    end
  end

  property p_frame_ends_cr;
    @(posedge clk_sys) disable iff (!resetn)
    tx_valid && idx == last |-> tx_data == CHR_CR;
  endproperty
  a_frame_ends_cr: assert property (p_frame_ends_cr) else $error("frame not ended by CR"); // R19

  property p_load_first;
    @(posedge clk_sys) disable iff (!resetn)
    load |=> tx_valid && tx_data == $past(frame[7:0]) && tx_data[6:5] != 2'b00;
  endproperty
  a_load_first: assert property (p_load_first) else $error("bad first frame byte"); // R19
endmodule // nsp_txframe
`default_nettype wire

// ===== nsp_interp.sv
`timescale 1ns/100ps
`default_nettype none
module nsp_interp import nsp_pkg::*; #(
  parameter int MOVE_TIMEOUT_CYC = MOVE_TIMEOUT_MS * CLK_KHZ,
  // identity strings and shutter commands: arbitrary neutral values
  parameter logic [39:0] VERSION_STR = 40'h56_312E_3030,
  parameter logic [63:0] NAME_STR = 64'h4E50_432D_3030_3031,
  parameter logic [31:0] SHUT_A_CLOSE = 32'h6343_4C53,
  parameter logic [31:0] SHUT_A_OPEN = 32'h634F_504E,
  parameter logic [31:0] SHUT_B_CLOSE = 32'h6353_4843,
  parameter logic [31:0] SHUT_B_OPEN = 32'h6353_484F
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [2:0] position,
  input wire logic panel_rot_start,
  input wire logic obj_leave,
  input wire logic obj_enter,
  input wire logic rot_done,
  input wire logic ctrl_forbid,
  input wire logic hw_fault,
  output logic move_req,
  output logic [2:0] move_target,
  output logic [1:0] status_mode
);
  nsp_state_t state;
  logic [7:0] rx_buf [0:RX_MAX-1];
  logic [3:0] rx_cnt;
  logic rx_ovf;
  logic cmd_go;
  logic [7:0] cmd_id;
  logic [7:0] data_ch;
  logic [7:0] echo [1:3];
  logic [23:0] cmd_word;
  logic has_data;
  logic [2:0] pos_eff;
  logic go_dig_ok;
  logic stat_dig_ok;
  logic d_move;
  logic [2:0] d_target;
  logic [7:0] d_id;
  logic [7:0] d_err;
  nsp_dkind_t d_kind;
  logic [7:0] d_ch;
  logic d_mode_we;
  logic [1:0] d_mode_val;
  logic [7:0] r_id;
  logic [23:0] r_cmd;
  nsp_dkind_t r_kind;
  logic [7:0] r_ch;
  logic [31:0] tmo;
  logic start_pend;
  logic end_pend;
  logic ev_start;
  logic ev_end;
  logic tx_busy;
  logic load_reply;
  logic load_ev;
  logic [7:0] f_id;
  logic [23:0] f_cmd;
  nsp_dkind_t f_kind;
  logic [7:0] f_ch;
  logic [7:0] dat [0:7];
  logic [3:0] dlen;
  logic [FRAME_BYTES*8-1:0] frame_flat;
  logic [4:0] frame_len;

  // receive side: bytes gathered until CR; no new byte while a frame is decoded
  assign rx_ready = (state == ST_IDLE) && !cmd_go;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_cnt <= 4'h0;
      rx_ovf <= 1'b0;
      cmd_go <= 1'b0;
    end else begin
      cmd_go <= 1'b0;
      if (cmd_go) begin
        rx_cnt <= 4'h0;
        rx_ovf <= 1'b0;
      end else if (rx_valid && rx_ready) begin
        if (rx_data == CHR_CR) begin
          cmd_go <= 1'b1; // R19
        end else if (rx_cnt < 4'(RX_MAX)) begin
          rx_cnt <= rx_cnt + 4'h1;
        end else begin
          rx_ovf <= 1'b1; // R20
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rx_valid && rx_ready && rx_data != CHR_CR && rx_cnt < 4'(RX_MAX)) begin
      rx_buf[rx_cnt[2:0]] <= rx_data; // R21
    end
  end

  // short command fields are echoed padded with '?'
  always_comb begin
    for (int i = 1; i < 4; i++) begin
      echo[i] = (rx_cnt > 4'(i)) ? rx_buf[i] : CHR_QMARK;
    end
    cmd_word = {echo[1], echo[2], echo[3]};
    cmd_id = (rx_cnt != 4'h0) ? rx_buf[0] : CHR_NUL;
    has_data = rx_cnt >= 4'h5;
    data_ch = rx_buf[4];
  end

  assign pos_eff = (position >= POS_FIRST && position <= POS_LAST) ? position : POS_NONE; // R10
  assign go_dig_ok = has_data && data_ch >= CHR_ONE && data_ch <= CHR_FIVE;
  assign stat_dig_ok = has_data && data_ch >= CHR_ZERO && data_ch <= CHR_THREE;

  // decode of one received frame into an action and a reply
  always_comb begin
    d_move = 1'b0;
    d_target = pos_eff;
    d_id = ID_ACK_CTL;
    d_err = CHR_NUL;
    d_kind = DK_NONE;
    d_ch = CHR_ZERO;
    d_mode_we = 1'b0;
    d_mode_val = MODE_OFF;
    if (rx_ovf) begin
      d_err = ERR_OVF; // R20
    end else if (hw_fault) begin
      d_err = ERR_HW; // R20
    end else if (cmd_id == ID_CTL && cmd_word == CMD_FWD) begin
      if (ctrl_forbid || pos_eff == POS_NONE) begin
        d_err = ERR_FORBID;
      end else begin
        d_move = 1'b1;
        d_target = (pos_eff == POS_LAST) ? POS_FIRST : pos_eff + 3'h1; // R5
      end
    end else if (cmd_id == ID_CTL && cmd_word == CMD_REV_G) begin
      if (ctrl_forbid || pos_eff == POS_NONE || pos_eff == POS_FIRST) begin
        d_err = ERR_FORBID; // R6
      end else begin
        d_move = 1'b1;
        d_target = pos_eff - 3'h1; // R6
      end
    end else if (cmd_id == ID_CTL && cmd_word == CMD_REV_U) begin
      if (ctrl_forbid || pos_eff == POS_NONE) begin
        d_err = ERR_FORBID;
      end else begin
        d_move = 1'b1;
        d_target = (pos_eff == POS_FIRST) ? POS_LAST : pos_eff - 3'h1; // R7
      end
    end else if (cmd_id == ID_CTL && cmd_word == CMD_GOTO) begin
      if (ctrl_forbid) begin
        d_err = ERR_FORBID;
      end else if (!go_dig_ok) begin
        d_err = ERR_DATA; // R23
      end else if (data_ch[2:0] != pos_eff) begin
        d_move = 1'b1;
        d_target = data_ch[2:0]; // R8
      end
    end else if (cmd_id == ID_CTL && cmd_word == CMD_STAT_W) begin
      if (!stat_dig_ok) begin
        d_err = ERR_DATA; // R23
      end else begin
        d_mode_we = 1'b1;
        d_mode_val = data_ch[1:0]; // R14
      end
    end else if (cmd_id == ID_CTL && cmd_word == CMD_DEFAULTS) begin
      d_mode_we = 1'b1;
      d_mode_val = MODE_OFF; // R18
    end else if (cmd_id == ID_READ && cmd_word == CMD_POS_Q) begin
      d_id = ID_ACK_RD; // R11
      d_kind = DK_CHAR;
      d_ch = CHR_ZERO | {5'h00, pos_eff}; // R10
    end else if (cmd_id == ID_READ && cmd_word == CMD_REV_Q) begin
      d_id = ID_ACK_RD;
      d_kind = DK_VER; // R12
    end else if (cmd_id == ID_READ && cmd_word == CMD_NAME_Q) begin
      d_id = ID_ACK_RD;
      d_kind = DK_NAME; // R13
    end else if (cmd_id == ID_READ && cmd_word == CMD_STAT_Q) begin
      d_id = ID_ACK_RD;
      d_kind = DK_CHAR;
      d_ch = CHR_ZERO | {6'h00, status_mode}; // R15
    end else begin
      d_err = ERR_CMD; // R20
    end
    if (d_err != CHR_NUL) begin
      d_id = ID_NAK; // R9
      d_move = 1'b0;
      d_kind = DK_CHAR;
      d_ch = d_err;
      d_mode_we = 1'b0;
    end
  end

  // a move reply waits for the motor, bounded by the timeout
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      r_id <= ID_ACK_CTL;
      r_cmd <= CMD_FWD;
      r_kind <= DK_NONE;
      r_ch <= CHR_ZERO;
      tmo <= 32'h0000_0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_go) begin
            r_id <= d_id;
            r_cmd <= cmd_word;
            r_kind <= d_kind;
            r_ch <= d_ch;
            tmo <= 32'h0000_0000;
            state <= d_move ? ST_MOVE : ST_REPLY;
          end
        end
        ST_MOVE: begin
          tmo <= tmo + 32'h0000_0001;
          if (rot_done) begin
            r_id <= ID_ACK_CTL; // R9
            r_kind <= DK_NONE;
            state <= ST_REPLY;
          end else if (hw_fault || tmo == 32'(MOVE_TIMEOUT_CYC - 1)) begin
            r_id <= ID_NAK;
            r_kind <= DK_CHAR;
            r_ch <= hw_fault ? ERR_HW : ERR_TIMEOUT; // R20
            state <= ST_REPLY;
          end
        end
        ST_REPLY: begin
          if (load_reply) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      move_req <= 1'b0;
      move_target <= POS_NONE;
    end else begin
      move_req <= (state == ST_IDLE) && cmd_go && d_move;
      if ((state == ST_IDLE) && cmd_go && d_move) begin
        move_target <= d_target;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_mode <= MODE_OFF;
    end else if ((state == ST_IDLE) && cmd_go && d_mode_we) begin
      status_mode <= d_mode_val; // R14
    end
  end

  // unsolicited frames: fire and forget, a new event wins over the clear
  assign ev_start = move_req || panel_rot_start || obj_leave;
  assign ev_end = rot_done || obj_enter;
  assign load_reply = (state == ST_REPLY) && !tx_busy;
  assign load_ev = !tx_busy && (state != ST_REPLY) && (start_pend || end_pend); // R17

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      start_pend <= 1'b0;
      end_pend <= 1'b0;
    end else begin
      if (status_mode != MODE_OFF && ev_start) begin
        start_pend <= 1'b1; // R1 R3
      end else if (load_ev) begin
        start_pend <= 1'b0;
      end
      if (status_mode != MODE_OFF && ev_end) begin
        end_pend <= 1'b1; // R2 R4
      end else if (load_ev && !start_pend) begin
        end_pend <= 1'b0;
      end
    end
  end

  always_comb begin
    f_id = r_id;
    f_cmd = r_cmd;
    f_kind = r_kind;
    f_ch = r_ch;
    if (state != ST_REPLY) begin
      f_kind = DK_NONE;
      if (status_mode[1]) begin
        if (status_mode == MODE_SHUT_A) begin
          {f_id, f_cmd} = start_pend ? SHUT_A_CLOSE : SHUT_A_OPEN; // R3 R4
        end else begin
          {f_id, f_cmd} = start_pend ? SHUT_B_CLOSE : SHUT_B_OPEN; // R3 R4
        end
      end else begin
        f_id = ID_STATUS;
        f_cmd = CMD_STAT_EV;
        f_kind = DK_CHAR;
        f_ch = start_pend ? CHR_ZERO : (CHR_ZERO | {5'h00, pos_eff}); // R16
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dat[i] = (f_kind == DK_NAME) ? NAME_STR[63-8*i -: 8] : CHR_NUL;
    end
    unique case (f_kind)
      DK_NONE: dlen = 4'h0;
      DK_CHAR: begin
        dlen = 4'h1;
        dat[0] = f_ch;
      end
      DK_VER: begin
        dlen = 4'h5; // R12
        for (int i = 0; i < 5; i++) begin
          dat[i] = VERSION_STR[39-8*i -: 8];
        end
      end
      DK_NAME: dlen = 4'h8; // R13
    endcase
    for (int i = 0; i < FRAME_BYTES; i++) begin
      if (i == 0) begin
        frame_flat[i*8 +: 8] = f_id;
      end else if (i < 4) begin
        frame_flat[i*8 +: 8] = f_cmd[8*(3-i) +: 8];
      end else if (i - 4 < int'(dlen)) begin
        frame_flat[i*8 +: 8] = dat[3'(i-4)];
      end else if (i - 4 == int'(dlen)) begin
        frame_flat[i*8 +: 8] = CHR_CR; // R19
      end else begin
        frame_flat[i*8 +: 8] = CHR_NUL;
      end
    end
    frame_len = 5'h05 + {1'b0, dlen};
  end

  nsp_txframe #(
    .NBYTES(FRAME_BYTES)
  ) u_tx (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(load_reply || load_ev),
    .frame(frame_flat),
    .len(frame_len),
    .busy(tx_busy),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

  property p_status_start;
    @(posedge clk_sys) disable iff (!resetn)
    status_mode == MODE_STATUS && panel_rot_start |=> start_pend;
  endproperty
  a_status_start: assert property (p_status_start) else $error("start status lost"); // R1

  property p_status_end;
    @(posedge clk_sys) disable iff (!resetn)
    status_mode == MODE_STATUS && (rot_done || obj_enter) |=> end_pend;
  endproperty
  a_status_end: assert property (p_status_end) else $error("end status lost"); // R2

  property p_shutter_close;
    @(posedge clk_sys) disable iff (!resetn)
    status_mode[1] && obj_leave ##1 load_ev && start_pend
      |-> {f_id, f_cmd} == ((status_mode == MODE_SHUT_A) ? SHUT_A_CLOSE : SHUT_B_CLOSE);
  endproperty
  a_shutter_close: assert property (p_shutter_close) else $error("shutter close not sent"); // R3

  property p_guard_wrap;
    @(posedge clk_sys) disable iff (!resetn)
    state == ST_IDLE && cmd_go && cmd_id == ID_CTL && cmd_word == CMD_REV_G
      && position == POS_FIRST && !rx_ovf && !hw_fault
      |=> !move_req && state == ST_REPLY && r_id == ID_NAK && r_ch == ERR_FORBID;
  endproperty
  a_guard_wrap: assert property (p_guard_wrap) else $error("guarded wrap not refused"); // R6

  property p_move_ack;
    @(posedge clk_sys) disable iff (!resetn)
    state == ST_MOVE && rot_done |=> state == ST_REPLY && r_id == ID_ACK_CTL
      && r_kind == DK_NONE;
  endproperty
  a_move_ack: assert property (p_move_ack) else $error("move not acknowledged"); // R9

  property p_mode_write;
    @(posedge clk_sys) disable iff (!resetn)
    state == ST_IDLE && cmd_go && cmd_id == ID_CTL && cmd_word == CMD_STAT_W
      && stat_dig_ok && !rx_ovf && !hw_fault |=> status_mode == $past(data_ch[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("setting not stored"); // R14

  property p_defaults;
    @(posedge clk_sys) disable iff (!resetn)
    state == ST_IDLE && cmd_go && cmd_id == ID_CTL && cmd_word == CMD_DEFAULTS
      && !rx_ovf && !hw_fault |=> status_mode == MODE_OFF && r_id == ID_ACK_CTL;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not restored"); // R18

  property p_bad_digit;
    @(posedge clk_sys) disable iff (!resetn)
    state == ST_IDLE && cmd_go && cmd_id == ID_CTL && cmd_word == CMD_STAT_W
      && !stat_dig_ok && !rx_ovf && !hw_fault |=> $stable(status_mode) && r_ch == ERR_DATA;
  endproperty
  a_bad_digit: assert property (p_bad_digit) else $error("bad digit accepted"); // R23
endmodule // nsp_interp
`default_nettype wire

// ===== nsp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module nsp_host_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  output logic tx_ready
);
  // pure sink: the host never answers a status frame, so nothing flows back
  // slow mode stalls three cycles in four to stretch every reply
  always @(negedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ($urandom_range(0, 3) == 0) : ($urandom_range(0, 3) != 0);
    end
  end
endmodule // nsp_host_model
`default_nettype wire

// ===== nsp_interp_tb.sv
`timescale 1ns/100ps
`default_nettype none
module nsp_interp_tb import nsp_pkg::*;;
  localparam int TO_CYC = 50;
  logic clk_sys, resetn, rx_valid, rx_ready, tx_valid, tx_ready, slow, motor_en;
  logic [7:0] rx_data, tx_data;
  logic [2:0] position, move_target;
  logic panel_rot_start, obj_leave, obj_enter, rot_done, ctrl_forbid, hw_fault, move_req;
  logic [1:0] status_mode;
  logic [7:0] exp_q[$];
  logic [2:0] tgt_q[$];
  int error_cnt, compares, mv_cnt, cyc, dig;

  nsp_interp #(.MOVE_TIMEOUT_CYC(TO_CYC)) u_dut (.clk_sys, .resetn, .rx_data, .rx_valid,
    .rx_ready, .tx_data, .tx_valid, .tx_ready, .position, .panel_rot_start, .obj_leave,
    .obj_enter, .rot_done, .ctrl_forbid, .hw_fault, .move_req, .move_target, .status_mode);

  nsp_host_model u_host (.clk_sys, .resetn, .slow, .tx_ready);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic mism(input string m);
    $display("MISMATCH %0t %s", $time, m);
    error_cnt++;
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got);
    logic [7:0] e;
    compares++;
    if (exp_q.size() == 0) begin
      mism($sformatf("unexpected tx byte %h", got));
    end else begin
      e = exp_q.pop_front();
      if (got !== e) mism($sformatf("tx byte %h expected %h", got, e));
    end
  endtask

  task automatic cmp_tgt(input logic [2:0] got);
    logic [2:0] e;
    compares++;
    if (tgt_q.size() == 0) begin
      mism($sformatf("unexpected move to %h", got));
    end else begin
      e = tgt_q.pop_front();
      if (got !== e) mism($sformatf("move target %h expected %h", got, e));
    end
  endtask

  task automatic cmp_val(input logic [7:0] got, input logic [7:0] e, input string m);
    compares++;
    if (got !== e) mism(m);
  endtask

  task automatic expect_frame(input string s);
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
    exp_q.push_back(CHR_CR);
  endtask

  // valid stays up across the frame so no step sees it assigned twice
  task automatic send_frame(input string s);
    int n;
    n = 0;
    for (int i = 0; i <= s.len(); i++) begin
      rx_data = (i == s.len()) ? CHR_CR : s[i];
      rx_valid = 1'b1;
      while (rx_ready !== 1'b1 && n < 1000) begin
        @(negedge clk_sys);
        n++;
      end
      @(negedge clk_sys);
    end
    rx_valid = 1'b0;
    if (n >= 1000) mism("rx stuck");
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || tx_valid !== 1'b0 || rx_ready !== 1'b1) && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 3000) mism("no reply");
    if (tgt_q.size() != 0) mism("expected move never requested");
    tgt_q.delete();
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic run(input string c, input string r, input int tgt);
    if (tgt > 0) tgt_q.push_back(tgt[2:0]);
    expect_frame(r);
    send_frame(c);
    wait_done();
  endtask

  task automatic pulse(input int k);
    if (k == 0) panel_rot_start = 1'b1;
    else if (k == 1) obj_leave = 1'b1;
    else obj_enter = 1'b1;
    @(negedge clk_sys);
    panel_rot_start = 1'b0;
    obj_leave = 1'b0;
    obj_enter = 1'b0;
    wait_done();
  endtask

  // motor stand-in: random settle time, position follows the target on completion
  always @(negedge clk_sys) begin
    rot_done = 1'b0;
    if (move_req === 1'b1) begin
      cmp_tgt(move_target);
      if (motor_en) mv_cnt = 2 + $urandom_range(0, 6);
    end else if (mv_cnt > 0) begin
      mv_cnt--;
      if (mv_cnt == 0) begin
        position = move_target;
        rot_done = 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (resetn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) cmp_byte(tx_data);
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      mism("timeout");
      finish_test();
    end
  end

  initial begin
    resetn = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    position = 3'h3;
    {panel_rot_start, obj_leave, obj_enter, ctrl_forbid, hw_fault, slow} = 6'h00;
    motor_en = 1'b1;
    {mv_cnt, cyc, error_cnt, compares} = '0;
    void'($urandom(32'hf8ff_6bde));
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    cmp_val({6'h00, status_mode}, 8'h00, "reset mode");
    cmp_val({7'h00, tx_valid}, 8'h00, "reset tx");
    run("rPNM", "aPNMNPC-0001", 0);
    run("rVER", "aVERV1.00", 0);
    run("rRAR", "aRAR3", 0);
    position = 3'h7;
    run("rRAR", "aRAR0", 0);
    position = 3'h3;
    slow = 1'b1;
    run("cRCW", "oRCW", 4);
    slow = 1'b0;
    run("cRCC", "oRCC", 3);
    run("cRDC1", "oRDC", 1);
    run("cRCR", "nRCRf", 0);
    run("cRCC", "oRCC", 5);
    run("cRCW", "oRCW", 1);
    run("cRDC2", "oRDC", 2);
    run("cRCR", "oRCR", 1);
    // random gotos; the last one parks at hole 1 for the steps below
    for (int j = 0; j < 5; j++) begin
      dig = (j == 4) ? 1 : 1 + int'($urandom_range(0, 4));
      run($sformatf("cRDC%0d", dig), "oRDC", (dig == int'(position)) ? 0 : dig);
    end
    run("cRDC6", "nRDCb", 0);
    run("cRDC0", "nRDCb", 0);
    run("cRDC1", "oRDC", 0);
    run("rXYZ", "nXYZa", 0);
    run("rR", "nR??a", 0);
    run("cRAR", "nRARa", 0);
    run("rRAR12345", "nRAR4", 0);
    ctrl_forbid = 1'b1;
    run("cRCW", "nRCWf", 0);
    ctrl_forbid = 1'b0;
    hw_fault = 1'b1;
    run("rRAR", "nRAR5", 0);
    hw_fault = 1'b0;
    motor_en = 1'b0;
    run("cRCW", "nRCWd", 2);
    motor_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      run($sformatf("cSAS%0d", k), "oSAS", 0);
      run("rSAR", $sformatf("aSAR%0d", k), 0);
      cmp_val({6'h00, status_mode}, k[7:0], "mode");
    end
    run("cSAS4", "nSASb", 0);
    run("rSAR", "aSAR3", 0);
    expect_frame("cSHC");
    pulse(1);
    expect_frame("cSHO");
    pulse(2);
    run("cSAS2", "oSAS", 0);
    expect_frame("cCLS");
    pulse(0);
    expect_frame("cOPN");
    pulse(2);
    run("cSAS1", "oSAS", 0);
    expect_frame("sSAE0");
    pulse(1);
    expect_frame("sSAE1");
    pulse(2);
    expect_frame("sSAE0");
    pulse(0);
    expect_frame("sSAE0");
    expect_frame("oRCW");
    run("cRCW", "sSAE2", 2);
    run("cDEF", "oDEF", 0);
    run("rSAR", "aSAR0", 0);
    cmp_val({6'h00, status_mode}, 8'h00, "defaults mode");
    finish_test();
  end
endmodule // nsp_interp_tb
`default_nettype wire
